// ### core/free_running_timer_pkg.sv
// Register map, field layout and reset values of the free running timer
package free_running_timer_pkg;
    localparam logic [5:0] identification_off = 6'h00;
    localparam logic [5:0] clock_enable_ctrl_off = 6'h04;
    localparam logic [5:0] soft_reset_ctrl_off = 6'h08;
    localparam logic [5:0] timer_control_off = 6'h0c;
    localparam logic [5:0] timer_status_off = 6'h10;
    localparam logic [5:0] irq_enable_off = 6'h14;
    localparam logic [5:0] irq_raw_status_off = 6'h18;
    localparam logic [5:0] reserved_slot_off = 6'h1c;
    localparam logic [5:0] irq_clear_off = 6'h20;
    localparam logic [5:0] match_data_off = 6'h24;
    localparam logic [5:0] match_data_buffer_off = 6'h28;
    localparam logic [5:0] counter_value_off = 6'h2c;

    localparam int counter_clock_enable_bit = 0;
    localparam int debug_clock_enable_bit = 31;
    localparam int soft_reset_bit = 0;
    localparam int start_bit = 0;
    localparam int count_divider_lsb = 16;
    localparam int count_divider_msb = 22;
    localparam int soft_reset_busy_bit = 0;
    localparam int match_bit = 2;
    localparam int irq_enable_low_msb = 1;

    localparam logic [6:0] count_divider_reset = 7'h01;
    localparam logic start_reset = 1'b1;
    localparam logic counter_clock_enable_reset = 1'b1;
    localparam logic debug_clock_enable_reset = 1'b0;
    localparam logic [1:0] irq_enable_low_reset = 2'h1;
    localparam logic irq_match_enable_reset = 1'b0;
    localparam logic [31:0] zero_word = 32'h00000000;
    localparam logic [31:0] one_word = 32'h00000001;
    // Duration of the software reset seen in the status register
    localparam logic [1:0] soft_reset_cycles = 2'h2;
endpackage : free_running_timer_pkg

// ### core/free_running_timer.sv
// Free running 32-bit match timer with APB register bank
//
// Functional notes
// - 32-bit unsigned free running up-counter
// - Source is ring oscillator or sub clock
// - Count clock is source over prescale, divider plus one
// - Writing start one copies data to buffer
// - Count up each count clock, wrap to zero
// - Match event when counter equals buffer
// - Live counter readable at any time
// - Interrupt clear register write with bit two set clears pending match
// - Write-only counter clock enable, resets one
// - Read-write debug clock enable, resets zero
// - Soft reset clears all but clock enable
// - Fixed read-only identification word
// - Ring oscillator keeps counting in stop, wakes
// - Start zero stops, resets dividers, keeps registers
// - Soft reset status high while reset runs
// - Match interrupt gated by enable bit two
// - Count divider bits 22:16, resets to one
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
module free_running_timer #(
    // Arbitrary neutral identification value
    parameter logic [31:0] identification_value = 32'h00a5_0001
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ring_oscillator_clock,
    input wire logic sub_clock,
    input wire logic source_select_ring,
    input wire logic [1:0] prescale_divider,
    input wire logic stop_mode,
    input wire logic debug_mode,
    output logic match_irq,
    output logic wake_request
);
    localparam logic [5:0] last_off = free_running_timer_pkg::counter_value_off;

    logic [31:0] prdata_reg;
    logic start_reg;
    logic [6:0] count_divider_reg;
    logic counter_clock_enable_reg;
    logic debug_clock_enable_reg;
    logic [1:0] irq_enable_low_reg;
    logic irq_match_enable_reg;
    logic match_raw_reg;
    logic [31:0] match_data_reg;
    logic [31:0] match_data_buffer_reg;
    logic [31:0] counter_reg;
    logic [31:0] counter_next;
    logic [1:0] soft_reset_count_reg;
    logic [1:0] prescale_count_reg;
    logic [6:0] divider_count_reg;
    logic [2:0] ring_sync_reg;
    logic [2:0] sub_sync_reg;
    logic match_irq_reg;
    logic wake_request_reg;

    logic wr_access;
    logic rd_setup;
    logic soft_reset_busy;
    logic source_tick;
    logic prescale_done;
    logic count_tick;
    logic run;
    logic match_event;
    logic icr_clear;
    logic [5:0] offset;

    function automatic logic is_mapped(input logic [31:0] addr);
        is_mapped = addr[1:0] == 2'h0 && addr[31:6] == 26'h0 &&
            addr[5:0] <= last_off &&
            addr[5:0] != free_running_timer_pkg::reserved_slot_off;
    endfunction : is_mapped

    function automatic logic wr_hit(input logic [5:0] off,
                                    input logic [5:0] target);
        wr_hit = off == target;
    endfunction : wr_hit

    assign offset = paddr[5:0];
    assign wr_access = psel && penable && pwrite && is_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign prdata = prdata_reg;
    assign soft_reset_busy = soft_reset_count_reg != 2'h0;
    assign match_irq = match_irq_reg;
    assign wake_request = wake_request_reg;

    // Pin clocks pass two flops; the third only feeds edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_sync_reg <= 3'h0;
            sub_sync_reg <= 3'h0;
        end else begin
            ring_sync_reg <= {ring_sync_reg[1:0], ring_oscillator_clock};
            sub_sync_reg <= {sub_sync_reg[1:0], sub_clock};
        end
    end

    // Source must be well below pclk/2 or edges are lost
    assign source_tick = source_select_ring ?
        (ring_sync_reg[1] && !ring_sync_reg[2]) :
        (sub_sync_reg[1] && !sub_sync_reg[2]);

    // Sub clock is gated in stop mode; ring oscillator keeps going
    assign run = start_reg && counter_clock_enable_reg && !soft_reset_busy &&
        !(debug_mode && !debug_clock_enable_reg) &&
        !(stop_mode && !source_select_ring);

    assign prescale_done = source_tick && prescale_count_reg == prescale_divider;
    assign count_tick = run && prescale_done &&
        divider_count_reg == count_divider_reg;
    assign counter_next = counter_reg + free_running_timer_pkg::one_word;
    assign match_event = count_tick &&
        counter_next == match_data_buffer_reg;
    assign icr_clear = wr_hit(offset, free_running_timer_pkg::irq_clear_off) &&
        wr_access && pwdata[free_running_timer_pkg::match_bit];

    // Dividers clear while stopped so a restart begins a fresh period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_count_reg <= 2'h0;
            divider_count_reg <= 7'h00;
        end else if (!run) begin
            prescale_count_reg <= 2'h0;
            divider_count_reg <= 7'h00;
        end else if (source_tick) begin
            if (prescale_done) begin
                prescale_count_reg <= 2'h0;
                divider_count_reg <= count_tick ? 7'h00 :
                    divider_count_reg + 7'h01;
            end else begin
                prescale_count_reg <= prescale_count_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_reg <= free_running_timer_pkg::zero_word;
        end else if (soft_reset_busy) begin
            counter_reg <= free_running_timer_pkg::zero_word;
        end else if (count_tick) begin
            counter_reg <= counter_next;
        end
    end

    // A repeated write restarts the busy window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_count_reg <= 2'h0;
        end else if (wr_access && pwdata[free_running_timer_pkg::soft_reset_bit]
                && wr_hit(offset, free_running_timer_pkg::soft_reset_ctrl_off)) begin
            soft_reset_count_reg <= free_running_timer_pkg::soft_reset_cycles;
        end else if (soft_reset_busy) begin
            soft_reset_count_reg <= soft_reset_count_reg - 2'h1;
        end
    end

    // Clock enable register survives the soft reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_clock_enable_reg <=
                free_running_timer_pkg::counter_clock_enable_reset;
            debug_clock_enable_reg <=
                free_running_timer_pkg::debug_clock_enable_reset;
        end else if (wr_access &&
                wr_hit(offset, free_running_timer_pkg::clock_enable_ctrl_off)) begin
            counter_clock_enable_reg <=
                pwdata[free_running_timer_pkg::counter_clock_enable_bit];
            debug_clock_enable_reg <=
                pwdata[free_running_timer_pkg::debug_clock_enable_bit];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_reg <= free_running_timer_pkg::start_reset;
            count_divider_reg <= free_running_timer_pkg::count_divider_reset;
        end else if (soft_reset_busy) begin
            start_reg <= free_running_timer_pkg::start_reset;
            count_divider_reg <= free_running_timer_pkg::count_divider_reset;
        end else if (wr_access &&
                wr_hit(offset, free_running_timer_pkg::timer_control_off)) begin
            start_reg <= pwdata[free_running_timer_pkg::start_bit];
            count_divider_reg <= pwdata[free_running_timer_pkg::count_divider_msb:
                free_running_timer_pkg::count_divider_lsb];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_low_reg <= free_running_timer_pkg::irq_enable_low_reset;
            irq_match_enable_reg <= free_running_timer_pkg::irq_match_enable_reset;
        end else if (soft_reset_busy) begin
            irq_enable_low_reg <= free_running_timer_pkg::irq_enable_low_reset;
            irq_match_enable_reg <= free_running_timer_pkg::irq_match_enable_reset;
        end else if (wr_access &&
                wr_hit(offset, free_running_timer_pkg::irq_enable_off)) begin
            irq_enable_low_reg <=
                pwdata[free_running_timer_pkg::irq_enable_low_msb:0];
            irq_match_enable_reg <= pwdata[free_running_timer_pkg::match_bit];
        end
    end

    // A match in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_raw_reg <= 1'b0;
        end else if (soft_reset_busy) begin
            match_raw_reg <= 1'b0;
        end else if (match_event) begin
            match_raw_reg <= 1'b1;
        end else if (icr_clear) begin
            match_raw_reg <= 1'b0;
        end
    end

    // Data is only staged here; the compare uses the buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_data_reg <= free_running_timer_pkg::zero_word;
        end else if (soft_reset_busy) begin
            match_data_reg <= free_running_timer_pkg::zero_word;
        end else if (wr_access &&
                wr_hit(offset, free_running_timer_pkg::match_data_off)) begin
            match_data_reg <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_data_buffer_reg <= free_running_timer_pkg::zero_word;
        end else if (soft_reset_busy) begin
            match_data_buffer_reg <= free_running_timer_pkg::zero_word;
        end else if (wr_access && pwdata[free_running_timer_pkg::start_bit] &&
                wr_hit(offset, free_running_timer_pkg::timer_control_off)) begin
            match_data_buffer_reg <= match_data_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_irq_reg <= 1'b0;
            wake_request_reg <= 1'b0;
        end else begin
            match_irq_reg <= match_raw_reg && irq_match_enable_reg;
            wake_request_reg <= match_raw_reg && irq_match_enable_reg &&
                stop_mode && source_select_ring;
        end
    end

    // Read data captured in the setup cycle, zero wait states
    // Write-only bits and unused fields read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= free_running_timer_pkg::zero_word;
        end else if (rd_setup) begin
            prdata_reg <= free_running_timer_pkg::zero_word;
            if (is_mapped(paddr)) begin
                case (offset)
                    free_running_timer_pkg::identification_off:
                        prdata_reg <= identification_value;
                    free_running_timer_pkg::clock_enable_ctrl_off:
                        prdata_reg[free_running_timer_pkg::debug_clock_enable_bit]
                            <= debug_clock_enable_reg;
                    free_running_timer_pkg::timer_control_off: begin
                        prdata_reg[free_running_timer_pkg::start_bit] <= start_reg;
                        prdata_reg[free_running_timer_pkg::count_divider_msb:
                            free_running_timer_pkg::count_divider_lsb]
                            <= count_divider_reg;
                    end
                    free_running_timer_pkg::timer_status_off:
                        prdata_reg[free_running_timer_pkg::soft_reset_busy_bit]
                            <= soft_reset_busy;
                    free_running_timer_pkg::irq_enable_off: begin
                        prdata_reg[free_running_timer_pkg::irq_enable_low_msb:0]
                            <= irq_enable_low_reg;
                        prdata_reg[free_running_timer_pkg::match_bit]
                            <= irq_match_enable_reg;
                    end
                    free_running_timer_pkg::irq_raw_status_off:
                        prdata_reg[free_running_timer_pkg::match_bit]
                            <= match_raw_reg;
                    free_running_timer_pkg::match_data_off:
                        prdata_reg <= match_data_reg;
                    free_running_timer_pkg::match_data_buffer_off:
                        prdata_reg <= match_data_buffer_reg;
                    free_running_timer_pkg::counter_value_off:
                        prdata_reg <= counter_reg;
                    default:
                        prdata_reg <= free_running_timer_pkg::zero_word;
                endcase
            end
        end
    end

    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        count_tick && !soft_reset_busy |=> counter_reg == $past(counter_reg)
            + 32'h1) else $error("counter did not step on tick");
    a_count_hold: assert property (@(posedge pclk)
        disable iff (!presetn)
        !run && !soft_reset_busy |=> $stable(counter_reg))
        else $error("counter moved while stopped");
    a_start_copy: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && offset == free_running_timer_pkg::timer_control_off &&
        pwdata[0] && !soft_reset_busy
        |=> match_data_buffer_reg == $past(match_data_reg))
        else $error("buffer not loaded on start");
    a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
        match_event && !soft_reset_busy |=> match_raw_reg ##1 match_irq ==
            irq_match_enable_reg) else $error("match not latched");
    a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
        icr_clear && !match_event |=> !match_raw_reg ##1 !match_irq)
        else $error("match clear lost");
    a_soft_busy: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && pwdata[0] &&
        offset == free_running_timer_pkg::soft_reset_ctrl_off
        |=> soft_reset_busy [*2] ##1 !soft_reset_busy)
        else $error("soft reset length wrong");
    a_soft_clear: assert property (@(posedge pclk)
        disable iff (!presetn)
        $fell(soft_reset_busy) |-> counter_reg == 32'h0 && !match_raw_reg &&
            count_divider_reg == 7'h01) else $error("soft reset left state");
    a_id_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && paddr == 32'h0 |=> prdata == identification_value)
        else $error("identification read wrong");
    a_div_gate: assert property (@(posedge pclk) disable iff (!presetn)
        count_tick |-> prescale_count_reg == prescale_divider &&
            divider_count_reg == count_divider_reg && source_tick)
        else $error("count tick off divider");
    a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode && !source_select_ring |-> !count_tick)
        else $error("sub clock counted in stop");

    // Gating, status and hold checks
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        match_irq == $past(match_raw_reg && irq_match_enable_reg))
        else $error("match interrupt not gated");
    a_wake_gate: assert property (@(posedge pclk) disable iff (!presetn)
        wake_request == $past(match_raw_reg && irq_match_enable_reg &&
            stop_mode && source_select_ring))
        else $error("wake request not gated");
    a_busy_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && is_mapped(paddr) &&
        offset == free_running_timer_pkg::timer_status_off
        |=> prdata == {31'h0, $past(soft_reset_busy)})
        else $error("reset status read wrong");
    a_clk_keep: assert property (@(posedge pclk) disable iff (!presetn)
        soft_reset_busy && !wr_access |=> $stable(counter_clock_enable_reg)
            && $stable(debug_clock_enable_reg))
        else $error("clock enable lost in soft reset");
    a_buf_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !soft_reset_busy && !(wr_access &&
            wr_hit(offset, free_running_timer_pkg::timer_control_off))
        |=> $stable(match_data_buffer_reg))
        else $error("buffer changed without start");
    a_div_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !run |=> prescale_count_reg == 2'h0 && divider_count_reg == 7'h00)
        else $error("dividers not cleared while stopped");
endmodule : free_running_timer

// ### dv/test_free_running_timer.sv
// Self-checking bench for the free running match timer
`timescale 1ns/1ns
module test_free_running_timer;
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
        logic err;
    } note_type;
    // Arbitrary identification value
    localparam logic [31:0] id_value = 32'h0000_c3d2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ring_oscillator_clock = 1'b0;
    logic sub_clock = 1'b0;
    logic source_select_ring = 1'b1;
    logic [1:0] prescale_divider = 2'h0;
    logic stop_mode = 1'b0;
    logic debug_mode = 1'b0;
    logic match_irq;
    logic wake_request;
    logic [1:0] ring_div = 2'h0;
    logic [2:0] sub_div = 3'h0;
    logic [31:0] seed = 32'h86e58843;
    int err_count = 0;
    int checks = 0;
    note_type notes[$];
    note_type cur;
    logic [31:0] ra[13] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h14,
        32'h18, 32'h1c, 32'h20, 32'h24, 32'h28, 32'h30, 32'h6};
    logic [31:0] re[13] = '{id_value, 32'h0, 32'h0, 32'h10001, 32'h0,
        32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [12:0] rerr = 13'h1880;
    logic cs[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [1:0] cp[5] = '{2'h0, 2'h1, 2'h0, 2'h3, 2'h1};
    logic [6:0] cc[5] = '{7'h1, 7'h2, 7'h0, 7'h4, 7'h4};
    logic [31:0] sa[6] = '{32'hc, 32'h14, 32'h24, 32'h28, 32'h18, 32'h4};
    logic [31:0] se[6] = '{32'h10001, 32'h1, 32'h0, 32'h0, 32'h0,
        32'h80000000};

    free_running_timer #(.identification_value(id_value)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .ring_oscillator_clock(ring_oscillator_clock),
        .sub_clock(sub_clock), .source_select_ring(source_select_ring),
        .prescale_divider(prescale_divider), .stop_mode(stop_mode),
        .debug_mode(debug_mode), .match_irq(match_irq),
        .wake_request(wake_request)
    );

    initial begin
        forever #5 pclk = ~pclk;
    end

    // Source clocks kept at a quarter (ring) and a sixth (sub) of pclk so no edge is lost
    always @(posedge pclk) begin
        ring_div <= ring_div + 2'h1;
        ring_oscillator_clock <= ring_div[1];
        sub_div <= (sub_div == 3'h5) ? 3'h0 : sub_div + 3'h1;
        sub_clock <= (sub_div < 3'h3);
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // Expected answer is noted before the transfer; the monitor judges it
    task automatic xfer(input logic wr, input logic [31:0] a, d, e, m,
                        input logic er, output logic [31:0] v);
        int n;
        notes.push_back('{e, m, er});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            tally_and_finish();
        end
        v = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] v;
        xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0, v);
    endtask : wr

    task automatic rd(input logic [31:0] a, e, m, output logic [31:0] v);
        xfer(1'b0, a, 32'h0, e, m, 1'b0, v);
    endtask : rd

    // Read edges 240 cycles apart: a whole number of tick periods
    task automatic rate(output logic [31:0] diff);
        logic [31:0] a, b;
        repeat (20) @(posedge pclk);
        rd(32'h2c, 32'h0, 32'h0, a);
        repeat (237) @(posedge pclk);
        rd(32'h2c, 32'h0, 32'h0, b);
        diff = b - a;
    endtask : rate

    task automatic held();
        logic [31:0] a, b;
        repeat (10) @(posedge pclk);
        rd(32'h2c, 32'h0, 32'h0, a);
        repeat (40) @(posedge pclk);
        rd(32'h2c, a, 32'hffffffff, b);
    endtask : held

    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            if (notes.size() == 0) begin
                check("note_queue", 32'h0, 32'h1);
            end else begin
                cur = notes.pop_front();
                check("pslverr", {31'h0, pslverr}, {31'h0, cur.err});
                check("prdata", prdata & cur.mask, cur.exp & cur.mask);
            end
        end
    end

    initial begin
        repeat (100000) @(posedge pclk);
        err_count++;
        $display("timeout reached");
        tally_and_finish();
    end

    initial begin
        logic [31:0] v, s, d, r;
        int n;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            xfer(1'b0, ra[i], 32'h0, re[i], 32'hffffffff, rerr[i], v);
        end
        r = xs();
        xfer(1'b1, 32'h0, r, 32'h0, 32'h0, 1'b0, v);
        xfer(1'b1, 32'h1c, r, 32'h0, 32'h0, 1'b1, v);
        rd(32'h0, id_value, 32'hffffffff, v);
        wr(32'h4, 32'h80000001);
        rd(32'h4, 32'h80000000, 32'hffffffff, v);
        wr(32'h4, 32'h1);
        $display("test register map done");
        for (int i = 0; i < 5; i++) begin
            source_select_ring <= cs[i];
            prescale_divider <= cp[i];
            wr(32'hc, 32'h0);
            wr(32'hc, {9'h0, cc[i], 16'h1});
            rate(d);
            check("count rate", d, 32'hf0 / ((cs[i] ? 32'h4 : 32'h6) *
                ({30'h0, cp[i]} + 32'h1) * ({25'h0, cc[i]} + 32'h1)));
        end
        $display("test count rate done");
        source_select_ring <= 1'b1;
        prescale_divider <= 2'h0;
        r = xs();
        wr(32'h24, r);
        rd(32'h28, 32'h0, 32'hffffffff, v);
        wr(32'hc, 32'h1);
        rd(32'h28, r, 32'hffffffff, v);
        wr(32'hc, 32'h0);
        held();
        rd(32'h2c, 32'h0, 32'h0, v);
        rd(32'h24, r, 32'hffffffff, s);
        $display("test start and stop done");
        wr(32'h24, v + 32'h3);
        wr(32'h14, 32'h1);
        stop_mode <= 1'b1;
        wr(32'hc, 32'h1);
        rd(32'h28, v + 32'h3, 32'hffffffff, s);
        n = 0;
        s = 32'h0;
        while (s[2] !== 1'b1 && n < 100) begin
            rd(32'h18, 32'h0, 32'h0, s);
            n++;
        end
        check("raw match", {31'h0, s[2]}, 32'h1);
        check("masked irq", {31'h0, match_irq}, 32'h0);
        wr(32'h14, 32'h5);
        repeat (2) @(posedge pclk);
        check("match irq", {31'h0, match_irq}, 32'h1);
        check("wake", {31'h0, wake_request}, 32'h1);
        n = 0;
        d = v + 32'h3;
        while (d === v + 32'h3 && n < 100) begin
            rd(32'h2c, 32'h0, 32'h0, d);
            n++;
        end
        check("counter moved", {31'h0, d === v + 32'h3}, 32'h0);
        wr(32'h20, 32'h4);
        repeat (2) @(posedge pclk);
        check("cleared irq", {31'h0, match_irq}, 32'h0);
        rd(32'h18, 32'h0, 32'h4, s);
        stop_mode <= 1'b0;
        $display("test match done");
        wr(32'h4, 32'h80000000);
        held();
        wr(32'h4, 32'h1);
        debug_mode <= 1'b1;
        held();
        wr(32'h4, 32'h80000001);
        rate(d);
        check("debug count", d, 32'h3c);
        debug_mode <= 1'b0;
        source_select_ring <= 1'b0;
        stop_mode <= 1'b1;
        held();
        stop_mode <= 1'b0;
        source_select_ring <= 1'b1;
        $display("test gating done");
        wr(32'h8, 32'h0);
        rd(32'h24, v + 32'h3, 32'hffffffff, s);
        wr(32'h8, 32'h1);
        n = 0;
        s = 32'h1;
        while (s[0] !== 1'b0 && n < 10) begin
            rd(32'h10, 32'h0, 32'h0, s);
            n++;
        end
        check("reset status", {31'h0, s[0]}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(sa[i], se[i], 32'hffffffff, s);
        end
        $display("test soft reset done");
        tally_and_finish();
    end
endmodule : test_free_running_timer
